// *** core/context_save_and_trap_entry.sv ***
// register file, context save sequencer and trap/interrupt entry
//
// Overview of operation
// - sixteen 32-bit data and sixteen 32-bit address registers
// - data 15 implicit, address 10 stack, 11 return, 15 implicit
// - indices 0-7 are lower registers, 8-15 upper registers
// - address 0, 1, 8, 9 are global and never saved or restored
// - upper context: address 10-15, data 8-15, link word, status word
// - lower context: address 2-7, data 0-7, saved counter, link word
// - each saved context holds a link word chaining saved contexts
// - upper context saved on interrupt, trap and call; return frees the area without reloading registers
// - save area is sixteen words aligned on a sixteen-word boundary
// - free areas on a linked free list, allocated and freed by hardware
// - calls, interrupts and traps share one context switch mechanism
// - a whole context is written in two clock cycles
// - only the highest priority core request is presented
// - request priority selects the entry block in interrupt table
// - traps vector through a separate trap table of fixed blocks
// - a trap leaves the current interrupt priority unchanged
// - traps can never be masked
// - eight trap classes from reset to non-maskable interrupt
// - trap identification number written into data register 15
// - lowest pending trap identification number is taken
`include "ctx_trap_cfg.svh"
module context_save_and_trap_entry
(
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    // register write port from execution
    input  wire logic                        reg_we,
    input  wire logic                        reg_is_addr,
    input  wire logic [3:0]                  reg_idx,
    input  wire logic [31:0]                 reg_wdata,
    // register read port
    input  wire logic                        rd_is_addr,
    input  wire logic [3:0]                  rd_idx,
    output logic [31:0]                      rd_data,
    // context events
    input  wire logic                        call_req,
    input  wire logic                        ret_req,
    input  wire logic                        save_lower_req,
    input  wire logic [31:0]                 target_pc,
    input  wire logic [31:0]                 current_pc,
    // free list control
    input  wire logic                        free_head_we,
    input  wire logic [31:0]                 free_head_wdata,
    // interrupt request from router
    input  wire logic                        irq_valid,
    input  wire logic                        irq_to_core,
    input  wire logic [`IRQ_PRIO_W-1:0]      irq_prio,
    input  wire logic [31:0]                 irq_table_base,
    // trap sources
    input  wire logic [`TRAP_CLASSES-1:0]    trap_raise,
    input  wire logic [31:0]                 trap_table_base,
    // save area memory
    output logic                             mem_we,
    output logic [31:0]                      mem_addr,
    output logic [8*32-1:0]                  mem_wdata,
    input  wire logic [31:0]                 mem_free_next,
    // status and entry
    output logic [`IRQ_PRIO_W-1:0]           cur_prio,
    output logic [31:0]                      program_counter,
    output logic [31:0]                      previous_context_info,
    output logic [31:0]                      program_status_word,
    output logic [31:0]                      free_head,
    output logic                             busy,
    output logic                             entry_valid,
    output logic [`TRAP_CLASS_W-1:0]         last_trap_id
);
    import ctx_trap_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_global(input logic [3:0] idx);
        is_global = (idx == 4'h0) || (idx == 4'h1) || (idx == 4'h8) ||
                    (idx == 4'h9);
    endfunction

    function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                             input logic [7:0]  num,
                                             input int          shift);
        vec_addr = base | ({24'h0, num} << shift);
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [31:0] data_q [`REG_COUNT];
    logic [31:0] data_d [`REG_COUNT];
    logic [31:0] addr_q [`REG_COUNT];
    logic [31:0] addr_d [`REG_COUNT];
    seq_state_type state_q, state_d;
    save_cause_type cause_q, cause_d;
    logic [31:0] area_q, area_d;
    logic [31:0] previous_context_info_d, psw_d, pc_d, fh_d, rd_d;
    logic [8*32-1:0] wdata_d;
    logic [31:0] maddr_d;
    logic we_d, busy_d, ev_d;
    logic [`IRQ_PRIO_W-1:0] prio_d, pend_prio_q, pend_prio_d;
    logic [`TRAP_CLASS_W-1:0] tid_d, pend_tid_q, pend_tid_d;
    logic [`TRAP_CLASSES-1:0] tpend_q, tpend_d;
    logic any_trap;
    logic [`TRAP_CLASS_W-1:0] sel_trap;
    logic [31:0] ptr;

    trap_arbiter u_arb
    (
        .pending     (tpend_q),
        .any_pending (any_trap),
        .trap_id     (sel_trap)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        data_d      = data_q;
        addr_d      = addr_q;
        state_d     = state_q;
        cause_d     = cause_q;
        area_d      = area_q;
        previous_context_info_d      = previous_context_info;
        psw_d       = program_status_word;
        pc_d        = program_counter;
        fh_d        = free_head;
        prio_d      = cur_prio;
        tid_d       = last_trap_id;
        pend_prio_d = pend_prio_q;
        pend_tid_d  = pend_tid_q;
        tpend_d     = tpend_q | trap_raise;
        we_d        = 1'b0;
        ev_d        = 1'b0;
        wdata_d     = mem_wdata;
        maddr_d     = mem_addr;
        ptr         = {free_head[31:`AREA_ALIGN_BITS],
                       `AREA_ALIGN_BITS'h0};
        rd_d = rd_is_addr ? addr_q[rd_idx] : data_q[rd_idx];
        if (reg_we && state_q == ST_IDLE)
        begin
            if (reg_is_addr)
                addr_d[reg_idx] = reg_wdata;
            else
                data_d[reg_idx] = reg_wdata;
        end
        if (free_head_we && state_q == ST_IDLE)
            fh_d = free_head_wdata;
        unique case (state_q)
            ST_IDLE:
            begin
                if (any_trap || call_req || save_lower_req ||
                    (irq_valid && irq_to_core && irq_prio > cur_prio))
                begin
                    if (any_trap)
                    begin
                        cause_d    = CAUSE_TRAP;
                        pend_tid_d = sel_trap;
                        tpend_d[sel_trap] = trap_raise[sel_trap];
                    end
                    else if (irq_valid && irq_to_core && irq_prio > cur_prio)
                    begin
                        cause_d     = CAUSE_IRQ;
                        pend_prio_d = irq_prio;
                    end
                    else if (call_req)
                        cause_d = CAUSE_CALL;
                    else
                        cause_d = CAUSE_LOW;
                    if (free_head == `LINK_NULL)
                    begin
                        // a context trap taken without an area must not
                        // re-arm itself, or it would be taken forever
                        if (!(any_trap && sel_trap == `TRAP_CTX_CLASS))
                            tpend_d[`TRAP_CTX_CLASS] = 1'b1;
                        if (any_trap)
                            state_d = ST_VECTOR;
                    end
                    else
                    begin
                        area_d  = ptr;
                        state_d = ST_BEAT0;
                    end
                end
                else if (ret_req && previous_context_info != `LINK_NULL)
                begin
                    // keep upper registers as they are, free the area and unlink it
                    for (int i = 8; i < 16; i++)
                        data_d[i] = data_q[i];
                    fh_d   = previous_context_info;
                    previous_context_info_d = mem_free_next;
                    pc_d   = addr_q[`RETURN_ADDR_IDX];
                end
            end
            ST_BEAT0:
            begin
                we_d    = 1'b1;
                maddr_d = area_q;
                if (cause_q == CAUSE_LOW)
                    wdata_d = {previous_context_info, current_pc,
                               addr_q[7], addr_q[6], addr_q[5],
                               addr_q[4], addr_q[3], addr_q[2]};
                else
                    wdata_d = {previous_context_info, program_status_word,
                               addr_q[15], addr_q[14], addr_q[13],
                               addr_q[12], addr_q[11], addr_q[10]};
                state_d = ST_BEAT1;
            end
            ST_BEAT1:
            begin
                we_d    = 1'b1;
                maddr_d = area_q | 32'h0000_0020;
                wdata_d = (cause_q == CAUSE_LOW) ?
                    {data_q[7], data_q[6], data_q[5], data_q[4],
                     data_q[3], data_q[2], data_q[1], data_q[0]} :
                    {data_q[15], data_q[14], data_q[13], data_q[12],
                     data_q[11], data_q[10], data_q[9], data_q[8]};
                state_d = ST_LINK;
            end
            ST_LINK:
            begin
                previous_context_info_d  = area_q;
                fh_d    = mem_free_next;
                state_d = (cause_q == CAUSE_LOW) ? ST_IDLE : ST_VECTOR;
                if (cause_q == CAUSE_CALL)
                begin
                    addr_d[`RETURN_ADDR_IDX] = current_pc;
                    pc_d    = target_pc;
                    ev_d    = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_VECTOR:
            begin
                ev_d    = 1'b1;
                state_d = ST_IDLE;
                if (cause_q == CAUSE_TRAP)
                begin
                    data_d[`IMPLICIT_DATA] = {29'h0, pend_tid_q};
                    tid_d = pend_tid_q;
                    pc_d  = vec_addr(trap_table_base, {5'h0, pend_tid_q},
                                     `TRAP_ENTRY_SHIFT);
                end
                else
                begin
                    prio_d = pend_prio_q;
                    pc_d   = vec_addr(irq_table_base, pend_prio_q,
                                      `IRQ_ENTRY_SHIFT);
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        busy_d = (state_d != ST_IDLE);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
            begin
                data_q[i] <= 32'h0000_0000;
                addr_q[i] <= 32'h0000_0000;
            end
            state_q               <= ST_IDLE;
            cause_q               <= CAUSE_CALL;
            area_q                <= 32'h0000_0000;
            previous_context_info <= `LINK_NULL;
            program_status_word   <= `PSW_RESET;
            program_counter       <= 32'h0000_0000;
            free_head             <= `FREE_HEAD_RESET;
            cur_prio              <= '0;
            last_trap_id          <= '0;
            pend_prio_q           <= '0;
            pend_tid_q            <= '0;
            tpend_q               <= '0;
            mem_we                <= 1'b0;
            mem_addr              <= 32'h0000_0000;
            mem_wdata             <= '0;
            busy                  <= 1'b0;
            entry_valid           <= 1'b0;
            rd_data               <= 32'h0000_0000;
        end
        else
        begin
            data_q                <= data_d;
            addr_q                <= addr_d;
            state_q               <= state_d;
            cause_q               <= cause_d;
            area_q                <= area_d;
            previous_context_info <= previous_context_info_d;
            program_status_word   <= psw_d;
            program_counter       <= pc_d;
            free_head             <= fh_d;
            cur_prio              <= prio_d;
            last_trap_id          <= tid_d;
            pend_prio_q           <= pend_prio_d;
            pend_tid_q            <= pend_tid_d;
            tpend_q               <= tpend_d;
            mem_we                <= we_d;
            mem_addr              <= maddr_d;
            mem_wdata             <= wdata_d;
            busy                  <= busy_d;
            entry_valid           <= ev_d;
            rd_data               <= rd_d;
        end
    end
endmodule

// *** core/ctx_trap_cfg.svh ***
// constants for the context save and trap entry unit
`ifndef CTX_TRAP_CFG_SVH
`define CTX_TRAP_CFG_SVH
`define REG_COUNT        16
`define REG_IDX_W        4
`define UPPER_BASE_IDX   4'h8
`define IMPLICIT_DATA    4'hF
`define STACK_PTR_IDX    4'hA
`define RETURN_ADDR_IDX  4'hB
`define IMPLICIT_ADDR    4'hF
`define AREA_WORDS       16
`define AREA_ALIGN_BITS  6
`define LINK_NULL        32'h0000_0000
`define TRAP_CLASSES     8
`define TRAP_CLASS_W     3
`define TRAP_CTX_CLASS   3'h3
`define IRQ_PRIO_W       8
`define IRQ_ENTRY_SHIFT  5
`define TRAP_ENTRY_SHIFT 5
`define WORDS_PER_BEAT   8
`define BEATS_PER_SAVE   2
`define PSW_RESET        32'h0000_0B80
`define FREE_HEAD_RESET  32'h0000_0000
`endif

// *** core/ctx_trap_pkg.sv ***
// types shared by the context save and trap entry unit
package ctx_trap_pkg;
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_BEAT0  = 5'b00010,
        ST_BEAT1  = 5'b00100,
        ST_LINK   = 5'b01000,
        ST_VECTOR = 5'b10000
    } seq_state_type;

    typedef enum logic [1:0] {
        CAUSE_CALL = 2'h0,
        CAUSE_IRQ  = 2'h1,
        CAUSE_TRAP = 2'h2,
        CAUSE_LOW  = 2'h3
    } save_cause_type;
endpackage

// *** core/trap_arbiter.sv ***
// lowest identification number wins among pending traps
`include "ctx_trap_cfg.svh"
module trap_arbiter
(
    // pending trap classes
    input  wire logic [`TRAP_CLASSES-1:0] pending,
    // selected trap
    output logic                          any_pending,
    output logic [`TRAP_CLASS_W-1:0]      trap_id
);
    always_comb
    begin
        any_pending = |pending;
        trap_id     = '0;
        for (int i = `TRAP_CLASSES - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                trap_id = i[`TRAP_CLASS_W-1:0];
            end
        end
    end
endmodule

// *** test/ctx_trap_asserts.sv ***
// port assertions for the context save and trap entry unit
`include "ctx_trap_cfg.svh"
module ctx_trap_asserts
(
    // clock and reset
    input wire logic                     ref_clk,
    input wire logic                     arst_n,
    // requests
    input wire logic                     call_req,
    input wire logic                     ret_req,
    input wire logic [31:0]              target_pc,
    input wire logic                     irq_valid,
    input wire logic                     irq_to_core,
    input wire logic [`IRQ_PRIO_W-1:0]   irq_prio,
    input wire logic [31:0]              irq_table_base,
    input wire logic [`TRAP_CLASSES-1:0] trap_raise,
    input wire logic [31:0]              trap_table_base,
    // memory and state
    input wire logic                     mem_we,
    input wire logic [31:0]              mem_addr,
    input wire logic [31:0]              mem_free_next,
    input wire logic [`IRQ_PRIO_W-1:0]   cur_prio,
    input wire logic [31:0]              program_counter,
    input wire logic [31:0]              previous_context_info,
    input wire logic [31:0]              free_head,
    input wire logic                     busy,
    input wire logic                     entry_valid,
    input wire logic [`TRAP_CLASS_W-1:0] last_trap_id
);
    import ctx_trap_pkg::*;
    // ****************************************
    // helpers and sequences
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic irq_win;
    logic quiet;
    assign irq_win = irq_valid && irq_to_core && (irq_prio > cur_prio);
    assign quiet = !busy && (trap_raise == 0) && !irq_win;
    function automatic logic [31:0] low_id(input logic [7:0] p);
        logic [31:0] r;
        r = 0;
        for (int i = 7; i >= 0; i--)
            if (p[i])
                r = 32'(i);
        return r;
    endfunction
    sequence s_two_beats;
        mem_we ##1 mem_we ##1 !mem_we;
    endsequence
    sequence s_trap_take;
        !busy && (trap_raise != 0) && (free_head != 0);
    endsequence
    // ****************************************
    // properties
    // ****************************************
    a_call_save: assert property (
        quiet && call_req && free_head != 0 |-> ##2 s_two_beats)
        else $error("call save beats wrong");
    a_call_entry: assert property (
        quiet && call_req && free_head != 0 |-> ##4 entry_valid
        && program_counter == $past(target_pc, 4))
        else $error("call entry wrong");
    a_beat_pair: assert property (
        mem_we && !$past(mem_we) |=> mem_we
        && mem_addr == $past(mem_addr) + 32'h20)
        else $error("second beat wrong");
    a_area_align: assert property (
        mem_we && !$past(mem_we) |-> mem_addr[5:0] == 6'h00)
        else $error("save area misaligned");
    a_link_word: assert property (
        mem_we && !$past(mem_we) |-> ##2
        previous_context_info == $past(mem_addr, 2)
        && free_head == $past(mem_free_next))
        else $error("link word or free head wrong");
    a_ret_link: assert property (
        !busy && ret_req && trap_raise == 0 && !irq_win |=>
        free_head == $past(previous_context_info)
        && previous_context_info == $past(mem_free_next))
        else $error("return link wrong");
    a_empty_trap: assert property (
        quiet && call_req && free_head == 0 |=> !mem_we [*4])
        else $error("save with empty free list");
    a_trap_pick: assert property (
        s_trap_take |-> ##6 entry_valid
        && 32'(last_trap_id) == low_id($past(trap_raise, 6))
        && program_counter == ($past(trap_table_base, 6)
        | (low_id($past(trap_raise, 6)) << 5)))
        else $error("trap entry wrong");
    a_trap_prio: assert property (
        s_trap_take |=> $stable(cur_prio) [*5])
        else $error("trap changed priority");
    a_irq_entry: assert property (
        !busy && trap_raise == 0 && irq_win && free_head != 0
        |-> ##5 entry_valid && program_counter ==
        ($past(irq_table_base, 5) | (32'($past(irq_prio, 5)) << 5)))
        else $error("interrupt entry wrong");
    a_irq_refuse: assert property (
        !busy && irq_valid && !irq_win && trap_raise == 0
        && !call_req && !ret_req |=> !busy)
        else $error("interrupt taken wrongly");
endmodule
bind context_save_and_trap_entry ctx_trap_asserts u_chk (.ref_clk,
    .arst_n, .call_req, .ret_req, .target_pc, .irq_valid, .irq_to_core,
    .irq_prio, .irq_table_base, .trap_raise, .trap_table_base, .mem_we,
    .mem_addr, .mem_free_next, .cur_prio, .program_counter,
    .previous_context_info, .free_head, .busy, .entry_valid,
    .last_trap_id);

// *** test/save_mem_model.sv ***
// save area memory model answering link word lookups
module save_mem_model
(
    // clock
    input  wire logic         ref_clk,
    // save writes
    input  wire logic         mem_we,
    input  wire logic [31:0]  mem_addr,
    input  wire logic [255:0] mem_wdata,
    // lookup select
    input  wire logic         ret_req,
    input  wire logic [31:0]  free_head,
    input  wire logic [31:0]  previous_context_info,
    output logic      [31:0]  mem_free_next
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] saved_q [16];
    logic [31:0] look;
    // sixteen areas from 0x1000, free ones chained in address order
    assign look = ret_req ? previous_context_info : free_head;
    always @(posedge ref_clk)
        if (mem_we && mem_addr[5:0] == 6'h00)
            saved_q[mem_addr[9:6]] <= mem_wdata[255:224];
    assign mem_free_next = (look[31:10] != 22'h4) ? 32'h0 :
        ret_req ? saved_q[look[9:6]] :
        (look[9:6] == 4'hF) ? 32'h0 : look + 32'h40;
endmodule

// *** test/tb_context_save_and_trap_entry.sv ***
// self-checking bench for the context save and trap entry unit
`include "ctx_trap_cfg.svh"
module tb_context_save_and_trap_entry;
    timeunit 1ns;
    timeprecision 1ns;
    import ctx_trap_pkg::*;
    logic ref_clk, arst_n, reg_we, reg_is_addr, rd_is_addr, call_req;
    logic ret_req, save_lower_req, free_head_we, irq_valid, irq_to_core;
    logic mem_we, busy, entry_valid;
    logic [3:0] reg_idx, rd_idx;
    logic [7:0] irq_prio, trap_raise, cur_prio;
    logic [2:0] last_trap_id;
    logic [31:0] reg_wdata, rd_data, target_pc, current_pc, free_head;
    logic [31:0] free_head_wdata, irq_table_base, trap_table_base;
    logic [31:0] mem_addr, mem_free_next, program_counter;
    logic [31:0] previous_context_info, program_status_word;
    logic [255:0] mem_wdata;
    int bad_count;
    int checks;
    context_save_and_trap_entry u_dut (.ref_clk, .arst_n, .reg_we,
        .reg_is_addr, .reg_idx, .reg_wdata, .rd_is_addr, .rd_idx,
        .rd_data, .call_req, .ret_req, .save_lower_req, .target_pc,
        .current_pc, .free_head_we, .free_head_wdata, .irq_valid,
        .irq_to_core, .irq_prio, .irq_table_base, .trap_raise,
        .trap_table_base, .mem_we, .mem_addr, .mem_wdata, .mem_free_next,
        .cur_prio, .program_counter, .previous_context_info,
        .program_status_word, .free_head, .busy, .entry_valid,
        .last_trap_id);
    save_mem_model u_mem (.ref_clk, .mem_we, .mem_addr, .mem_wdata,
        .ret_req, .free_head, .previous_context_info, .mem_free_next);
    // ****************************************
    // helpers
    // ****************************************
    task automatic end_sim();
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [255:0] e, s);
        checks++;
        if (e !== s)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic wait_entry();
        int n;
        n = 0;
        do tick(1); while (entry_valid !== 1'b1 && ++n < 20);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do tick(1); while (busy !== 1'b0 && ++n < 20);
    endtask
    function automatic logic [31:0] rv(input logic a, input int i);
        return (a ? 32'hA000_0000 : 32'hD000_0000) | 32'(i);
    endfunction
    function automatic logic [255:0] seq8(input logic a, input int top);
        logic [255:0] r;
        for (int k = 0; k < 8; k++)
            r[255-32*k -: 32] = rv(a, top - k);
        return r;
    endfunction
    task automatic chk_save(input logic [255:0] e0, e1,
        input logic [31:0] area);
        int n;
        n = 0;
        while (mem_we !== 1'b1 && ++n < 20)
            tick(1);
        cmp("addr0", area, mem_addr);
        cmp("beat0", e0, mem_wdata);
        tick(1);
        cmp("addr1", area + 32'h20, mem_addr);
        cmp("beat1", e1, mem_wdata);
        tick(1);
        cmp("link", area, previous_context_info);
        cmp("free_head", area + 32'h40, free_head);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        for (int i = 0; i < 32; i++)
        begin
            {reg_we, reg_is_addr, reg_idx, reg_wdata} =
                {1'b1, i[4], i[3:0], rv(i[4], i % 16)};
            tick(1);
        end
        reg_we = 0;
        for (int i = 0; i < 32; i++)
        begin
            {rd_is_addr, rd_idx} = {i[4], i[3:0]};
            tick(1);
            cmp("rd_data", rv(i[4], i % 16), rd_data);
        end
    endtask
    task automatic t_call_lower_ret();
        logic [255:0] a;
        a = seq8(1, 15);
        target_pc = 32'h8000_0100;
        pulse(call_req);
        chk_save({32'h0, `PSW_RESET, a[255:64]}, seq8(0, 15), 32'h1000);
        cmp("entry", 1'b1, entry_valid);
        cmp("pc", target_pc, program_counter);
        wait_idle();
        a = seq8(1, 7);
        pulse(save_lower_req);
        chk_save({32'h1000, current_pc, a[255:64]}, seq8(0, 7), 32'h1040);
        wait_idle();
        pulse(ret_req);
        cmp("pc", current_pc, program_counter);
        cmp("free_head", 32'h1040, free_head);
        cmp("link", 32'h1000, previous_context_info);
    endtask
    task automatic t_irq();
        wait_idle();
        pulse(irq_valid);
        trap_raise = 8'h40;
        tick(1);
        trap_raise = 0;
        wait_entry();
        cmp("pc", 32'h0000_40A0, program_counter);
        cmp("cur_prio", 8'h05, cur_prio);
        wait_entry();
        cmp("trap_id", 3'h6, last_trap_id);
        wait_idle();
        irq_prio = 8'h03;
        pulse(irq_valid);
        cmp("busy", 1'b0, busy);
        {irq_prio, irq_to_core} = {8'h09, 1'b0};
        pulse(irq_valid);
        cmp("busy", 1'b0, busy);
    endtask
    logic [2:0] a_ids [3] = '{3'h2, 3'h5, 3'h7};
    task automatic t_traps();
        for (int id = 0; id < 8; id++)
        begin
            wait_idle();
            trap_raise = 8'(1 << id);
            tick(1);
            trap_raise = 0;
            wait_entry();
            cmp("trap_id", id[2:0], last_trap_id);
            cmp("pc", 32'h2000 | (id << 5), program_counter);
            cmp("cur_prio", 8'h05, cur_prio);
        end
        wait_idle();
        trap_raise = 8'hA4;
        tick(1);
        trap_raise = 0;
        foreach (a_ids[k])
        begin
            wait_entry();
            cmp("trap_id", a_ids[k], last_trap_id);
        end
        wait_idle();
        {rd_is_addr, rd_idx} = {1'b0, 4'hF};
        tick(1);
        cmp("d15", 32'h7, rd_data);
    endtask
    task automatic t_empty();
        free_head_wdata = 0;
        pulse(free_head_we);
        pulse(call_req);
        for (int i = 0; i < 4; i++)
        begin
            cmp("mem_we", 1'b0, mem_we);
            tick(1);
        end
        cmp("trap_id", 3'h3, last_trap_id);
        wait_idle();
        free_head_wdata = 32'h1380;
        pulse(free_head_we);
        cmp("free_head", 32'h1380, free_head);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        ref_clk = 0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        #100us;
        bad_count++;
        end_sim();
    end
    initial
    begin
        {arst_n, reg_we, reg_is_addr, reg_idx, reg_wdata} = 0;
        {rd_is_addr, rd_idx, call_req, ret_req, save_lower_req} = 0;
        {target_pc, free_head_we, irq_valid, trap_raise} = 0;
        {current_pc, irq_to_core, irq_prio} = {32'h8000_0200, 1'b1, 8'h05};
        {irq_table_base, trap_table_base} = {32'h4000, 32'h2000};
        free_head_wdata = 32'h1000;
        repeat (2) @(posedge ref_clk);
        #1 arst_n = 1;
        cmp("psw", `PSW_RESET, program_status_word);
        cmp("busy", 1'b0, busy);
        t_regs();
        pulse(free_head_we);
        t_call_lower_ret();
        t_irq();
        t_traps();
        t_empty();
        end_sim();
    end
endmodule
